// ---- afmc_defines.svh ----
/*
 * offsets, field positions, reset values and fixed sizes of the converter
 * fifo and mode control block.
 * assumes byte-wide registers addressed by an 8-bit register port.
 */
`ifndef AFMC_DEFINES_SVH
`define AFMC_DEFINES_SVH

// register offsets
`define AFMC_OFF_SC1 8'h10
`define AFMC_OFF_MODE 8'h12
`define AFMC_OFF_FIFO 8'h13
`define AFMC_OFF_RES_HI 8'h14
`define AFMC_OFF_RES_LO 8'h15
`define AFMC_OFF_IRQ_ST 8'h18
`define AFMC_OFF_IRQ_MASK 8'h19

// status_control_one fields
`define AFMC_SC1_CONT 5
`define AFMC_SC1_CH_HI 4

// mode_clock_control fields
`define AFMC_MODE_LOWPWR 7
`define AFMC_MODE_DIV_HI 6
`define AFMC_MODE_DIV_LO 5
`define AFMC_MODE_LONGSMP 4
`define AFMC_MODE_RES_HI 3
`define AFMC_MODE_RES_LO 2
`define AFMC_MODE_CLK_HI 1
`define AFMC_MODE_CLK_LO 0

// fifo_scan_compare_control fields
`define AFMC_FIFO_SCAN 6
`define AFMC_FIFO_COMB 5
`define AFMC_FIFO_DEP_HI 2

// interrupt status bits
`define AFMC_IRQ_DONE 0
`define AFMC_IRQ_CH_OVF 1
`define AFMC_IRQ_RES_LOST 2

// reset values
`define AFMC_RST_SC1 8'h1f
`define AFMC_RST_MODE 8'h00
`define AFMC_RST_MASK 8'h00

// sizes
`define AFMC_FIFO_LEVELS 8
`define AFMC_CH_W 5
`define AFMC_RES_W 10

`endif

// ---- afmc_pkg.sv ----
/*
 * types shared by the converter fifo and mode control modules.
 * assumes afmc_defines.svh is on the include path.
 */
`include "afmc_defines.svh"

package afmc_pkg;

    typedef enum logic [1:0] {
        AFMC_RES_8 = 2'h0,
        AFMC_RES_10 = 2'h1
    } afmc_res_e;

    typedef enum logic [1:0] {
        AFMC_CLK_BUS = 2'h0,
        AFMC_CLK_BUS_HALF = 2'h1,
        AFMC_CLK_ALT = 2'h2,
        AFMC_CLK_ASYNC = 2'h3
    } afmc_clk_e;

    typedef enum logic [2:0] {
        AFMC_ST_IDLE = 3'h1,
        AFMC_ST_BUSY = 3'h2,
        AFMC_ST_HOLD = 3'h4
    } afmc_state_e;

    typedef logic [3:0] afmc_count_t;

endpackage : afmc_pkg

// ---- afmc_fifo_if.sv ----
/*
 * port bundle between the control logic and one eight-entry fifo store.
 * assumes a single clock shared by both ends.
 */
`timescale 1ns/1ps
`default_nettype none

interface afmc_fifo_if #(parameter int W = 10);
    logic push;
    logic pop;
    logic clear;
    logic [W-1:0] wdata;
    logic [W-1:0] rdata;
    logic [3:0] count;

    modport owner (output push, output pop, output clear, output wdata,
                   input rdata, input count);
    modport store (input push, input pop, input clear, input wdata,
                   output rdata, output count);
endinterface : afmc_fifo_if

`default_nettype wire

// ---- afmc_fifo.sv ----
/*
 * eight-entry fifo store used for the channel list and the result list.
 * assumes the owner never pushes when full nor pops when empty; such
 * requests are dropped here as well.
 */
`timescale 1ns/1ps
`default_nettype none

module afmc_fifo
    import afmc_pkg::*;
#(
    parameter int W = 10
) (
    input wire logic MCLK,
    input wire logic RST_B,
    afmc_fifo_if.store f
);

    logic [W-1:0] mem [`AFMC_FIFO_LEVELS];
    logic [2:0] wr_ptr;
    logic [2:0] rd_ptr;
    afmc_count_t cnt;
    logic do_push, do_pop;

    assign do_push = f.push && (cnt != 4'h8);
    assign do_pop = f.pop && (cnt != 4'h0);
    assign f.rdata = mem[rd_ptr];
    assign f.count = cnt;

    always_ff @(posedge MCLK) begin
        if (do_push && !f.clear) begin
            mem[wr_ptr] <= f.wdata;
        end
    end

    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            wr_ptr <= 3'h0;
            rd_ptr <= 3'h0;
            cnt <= 4'h0;
        end else if (f.clear) begin
            wr_ptr <= 3'h0;
            rd_ptr <= 3'h0;
            cnt <= 4'h0;
        end else begin
            if (do_push) begin
                wr_ptr <= wr_ptr + 3'h1;
            end
            if (do_pop) begin
                rd_ptr <= rd_ptr + 3'h1;
            end
            cnt <= cnt + {3'h0, do_push} - {3'h0, do_pop};
        end
    end

endmodule : afmc_fifo

`default_nettype wire

// ---- afmc_ctrl.sv ----
/*
 * converter control: resolution and clock source selection, conversion
 * sequencing, channel and result fifos with scan mode and or/and
 * combining of compare triggers, register port and interrupt.
 * assumes the analog converter outside takes CONV_START with the channel,
 * answers with a one-cycle CONV_DONE carrying result and compare hit, and
 * that all inputs are synchronous to MCLK.
 */
// Functional notes
// - resolution code 01 selects 10-bit; codes 10 and 11 are reserved
// - resolution code 00 selects 8-bit conversions
// - clock select: bus, bus halved, alternate, converter async clock
// - fifo control bits 7 and 4:3 read zero and ignore writes
// - scan mode repeats first fifo channel until result fifo full
// - scan plus continuous restarts same channel once complete is set
// - combine clear: complete set when any compare trigger occurred
// - combine set: complete set only when every trigger occurred
// - depth zero disables the fifo, nonzero enables it
// - nonzero depth code gives depth of code plus one levels
// - with fifo on, channel writes push and result reads pop
// - with fifo on, conversions start once channel fifo reaches depth and result fifo is empty
// - with fifo on, complete set after whole set fills result fifo
// - with fifo on, result fifo is read via result high and low
`timescale 1ns/1ps
`default_nettype none

module afmc_ctrl
    import afmc_pkg::*;
(
    input wire logic MCLK,
    input wire logic RST_B,
    input wire logic [7:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output logic [7:0] REG_RDATA,
    output logic IRQ,
    input wire logic ALT_CLK_TICK,
    input wire logic ASYNC_CLK_TICK,
    output logic CONV_CLK_TICK,
    output logic CONV_START,
    output logic [4:0] CONV_CHANNEL,
    output logic CONV_RES_10,
    output logic CONV_LOW_POWER,
    output logic CONV_LONG_SAMPLE,
    input wire logic CONV_DONE,
    input wire logic [9:0] CONV_RESULT,
    input wire logic CONV_CMP_HIT
);

    afmc_fifo_if #(.W(`AFMC_CH_W)) ch_q ();
    afmc_fifo_if #(.W(`AFMC_RES_W)) res_q ();

    afmc_fifo #(.W(`AFMC_CH_W)) u_ch_fifo (
        .MCLK(MCLK),
        .RST_B(RST_B),
        .f(ch_q)
    );

    afmc_fifo #(.W(`AFMC_RES_W)) u_res_fifo (
        .MCLK(MCLK),
        .RST_B(RST_B),
        .f(res_q)
    );

    // software-visible registers
    logic [4:0] channel_select;
    logic continuous_conversion, conversion_complete_flag;
    logic [7:0] mode_clock_control;
    logic fifo_scan_enable, compare_combine_select;
    logic [2:0] fifo_depth;
    logic [9:0] result;
    logic [2:0] irq_status, irq_mask;

    afmc_state_e state;
    logic hit_any, hit_all, half_phase;
    logic [2:0] div_cnt;

    logic wr_sc1, wr_mode, wr_fifo, wr_mask, rd_lo, rd_st, fifo_en;
    afmc_count_t depth_lv;
    logic ch_ready, start_single, start_set, set_last, set_done, set_ok;
    logic next_hit_any, next_hit_all, src_tick;
    logic [2:0] div_top, ev;
    logic [7:0] next_rdata;

    assign wr_sc1 = REG_WR && (REG_ADDR == `AFMC_OFF_SC1);
    assign wr_mode = REG_WR && (REG_ADDR == `AFMC_OFF_MODE);
    assign wr_fifo = REG_WR && (REG_ADDR == `AFMC_OFF_FIFO);
    assign wr_mask = REG_WR && (REG_ADDR == `AFMC_OFF_IRQ_MASK);
    assign rd_lo = REG_RD && (REG_ADDR == `AFMC_OFF_RES_LO);
    assign rd_st = REG_RD && (REG_ADDR == `AFMC_OFF_IRQ_ST);

    assign fifo_en = (fifo_depth != 3'h0);
    assign depth_lv = {1'b0, fifo_depth} + 4'h1;

    assign ch_ready = fifo_en && (ch_q.count >= depth_lv)
                      && (res_q.count == 4'h0);
    assign start_single = !fifo_en && wr_sc1;
    assign start_set = (state == AFMC_ST_IDLE) && ch_ready;

    // the count after this push decides whether the set is complete
    assign set_last = (res_q.count + 4'h1) >= depth_lv;
    assign set_done = fifo_en && (state == AFMC_ST_BUSY) && CONV_DONE
                      && set_last;
    assign next_hit_any = hit_any | CONV_CMP_HIT;
    assign next_hit_all = hit_all & CONV_CMP_HIT;

    assign set_ok = compare_combine_select ? next_hit_all : next_hit_any;

    // channel writes push, result reads pop
    assign ch_q.push = fifo_en && wr_sc1;
    assign ch_q.wdata = REG_WDATA[`AFMC_SC1_CH_HI:0];
    assign res_q.pop = fifo_en && rd_lo;
    assign res_q.wdata = CONV_RESULT;
    assign res_q.push = fifo_en && (state == AFMC_ST_BUSY) && CONV_DONE
                        && (res_q.count != 4'h8);
    // a new depth or mode invalidates everything queued
    assign ch_q.clear = wr_fifo || wr_mode;
    assign res_q.clear = ch_q.clear;

    // scan reuses the head channel, otherwise the list advances
    assign ch_q.pop = fifo_en && !fifo_scan_enable && !ch_q.clear
                      && (start_set || ((state == AFMC_ST_BUSY)
                      && CONV_DONE && !set_last));

    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            channel_select <= 5'(`AFMC_RST_SC1);
            continuous_conversion <= 1'b0;
        end else if (wr_sc1) begin
            channel_select <= REG_WDATA[`AFMC_SC1_CH_HI:0];
            continuous_conversion <= REG_WDATA[`AFMC_SC1_CONT];
        end
    end

    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            mode_clock_control <= `AFMC_RST_MODE;
        end else if (wr_mode) begin
            mode_clock_control <= REG_WDATA;
            // reserved resolution codes keep the old resolution field
            if (REG_WDATA[`AFMC_MODE_RES_HI]) begin
                mode_clock_control[`AFMC_MODE_RES_HI:`AFMC_MODE_RES_LO]
                    <= mode_clock_control[`AFMC_MODE_RES_HI:
                                          `AFMC_MODE_RES_LO];
            end
        end
    end

    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            fifo_scan_enable <= 1'b0;
            compare_combine_select <= 1'b0;
            fifo_depth <= 3'h0;
        end else if (wr_fifo) begin
            fifo_scan_enable <= REG_WDATA[`AFMC_FIFO_SCAN];
            compare_combine_select <= REG_WDATA[`AFMC_FIFO_COMB];
            fifo_depth <= REG_WDATA[`AFMC_FIFO_DEP_HI:0];
        end
    end

    // resolution out; only codes 00 and 01 can be held
    assign CONV_RES_10 = (mode_clock_control[`AFMC_MODE_RES_HI:
                          `AFMC_MODE_RES_LO] == AFMC_RES_10);
    assign CONV_LOW_POWER = mode_clock_control[`AFMC_MODE_LOWPWR];
    assign CONV_LONG_SAMPLE = mode_clock_control[`AFMC_MODE_LONGSMP];

    always_comb begin
        case (afmc_clk_e'(mode_clock_control[`AFMC_MODE_CLK_HI:
                                             `AFMC_MODE_CLK_LO]))
            AFMC_CLK_BUS: src_tick = 1'b1;
            AFMC_CLK_BUS_HALF: src_tick = half_phase;
            AFMC_CLK_ALT: src_tick = ALT_CLK_TICK;
            AFMC_CLK_ASYNC: src_tick = ASYNC_CLK_TICK;
            default: src_tick = 1'b0;
        endcase
    end

    assign div_top = 3'((4'h1 << mode_clock_control[`AFMC_MODE_DIV_HI:
                                                   `AFMC_MODE_DIV_LO]) - 4'h1);

    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            half_phase <= 1'b0;
        end else begin
            half_phase <= !half_phase;
        end
    end

    // divider for the converter tick
    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            div_cnt <= 3'h0;
            CONV_CLK_TICK <= 1'b0;
        end else if (wr_mode) begin
            div_cnt <= 3'h0;
            CONV_CLK_TICK <= 1'b0;
        end else begin
            CONV_CLK_TICK <= src_tick && (div_cnt == div_top);
            if (src_tick) begin
                div_cnt <= (div_cnt == div_top) ? 3'h0 : div_cnt + 3'h1;
            end
        end
    end

    // conversion sequencer
    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            state <= AFMC_ST_IDLE;
            CONV_START <= 1'b0;
            CONV_CHANNEL <= 5'h00;
        end else begin
            CONV_START <= 1'b0;
            if (wr_mode || wr_fifo) begin
                state <= AFMC_ST_IDLE;
            end else if (start_single) begin
                // a channel write restarts a single conversion
                state <= AFMC_ST_BUSY;
                CONV_START <= 1'b1;
                CONV_CHANNEL <= REG_WDATA[`AFMC_SC1_CH_HI:0];
            end else begin
                case (state)
                    AFMC_ST_IDLE: begin
                        if (start_set) begin
                            state <= AFMC_ST_BUSY;
                            CONV_START <= 1'b1;
                            CONV_CHANNEL <= ch_q.rdata;
                        end
                    end
                    AFMC_ST_BUSY: begin
                        if (CONV_DONE && !fifo_en) begin
                            if (continuous_conversion) begin
                                CONV_START <= 1'b1;
                            end else begin
                                state <= AFMC_ST_IDLE;
                            end
                        end else if (CONV_DONE && !set_last) begin
                            CONV_START <= 1'b1;
                            CONV_CHANNEL <= ch_q.rdata;
                        end else if (CONV_DONE) begin
                            if (fifo_scan_enable && continuous_conversion) begin
                                CONV_START <= 1'b1;
                                state <= AFMC_ST_HOLD;
                            end else begin
                                state <= AFMC_ST_IDLE;
                            end
                        end
                    end
                    AFMC_ST_HOLD: begin
                        // every result in hold is dropped; the result fifo only takes pushes in busy
                        if (CONV_DONE && res_q.count == 4'h0) begin
                            state <= AFMC_ST_IDLE;
                        end else if (CONV_DONE) begin
                            CONV_START <= 1'b1;
                        end
                    end
                    default: state <= AFMC_ST_IDLE;
                endcase
            end
        end
    end

    // compare trigger accumulation across one set
    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            hit_any <= 1'b0;
            hit_all <= 1'b1;
        end else if (start_set || state == AFMC_ST_IDLE) begin
            hit_any <= 1'b0;
            hit_all <= 1'b1;
        end else if (fifo_en && state == AFMC_ST_BUSY && CONV_DONE) begin
            hit_any <= next_hit_any;
            hit_all <= next_hit_all;
        end
    end

    // result register used outside fifo mode
    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            result <= 10'h000;
        end else if (!fifo_en && state == AFMC_ST_BUSY && CONV_DONE) begin
            result <= CONV_RESULT;
        end
    end

    // complete flag: an event in a result-read clearing cycle still sets it; mode and fifo writes win in fifo mode, a channel write wins outside it
    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            conversion_complete_flag <= 1'b0;
        end else begin
            if (wr_mode || wr_fifo || (!fifo_en && (wr_sc1 || rd_lo))
                || (fifo_en && rd_lo && res_q.count == 4'h1)) begin
                conversion_complete_flag <= 1'b0;
            end
            if (!fifo_en && state == AFMC_ST_BUSY && CONV_DONE
                && !wr_sc1) begin
                conversion_complete_flag <= 1'b1;
            end
            if (set_done && set_ok && !wr_fifo && !wr_mode) begin
                conversion_complete_flag <= 1'b1;
            end
        end
    end

    // interrupt events: completion, channel overflow, result lost
    assign ev[`AFMC_IRQ_DONE] = (set_done && set_ok)
        || (!fifo_en && state == AFMC_ST_BUSY && CONV_DONE);
    assign ev[`AFMC_IRQ_CH_OVF] = ch_q.push && (ch_q.count == 4'h8);
    assign ev[`AFMC_IRQ_RES_LOST] = fifo_en && CONV_DONE
        && (state != AFMC_ST_IDLE) && (res_q.count == 4'h8);

    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            irq_status <= 3'h0;
        end else begin
            irq_status <= (rd_st ? 3'h0 : irq_status) | ev;
        end
    end

    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            irq_mask <= 3'(`AFMC_RST_MASK);
        end else if (wr_mask) begin
            irq_mask <= REG_WDATA[2:0];
        end
    end

    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            IRQ <= 1'b0;
        end else begin
            IRQ <= |(irq_status & irq_mask);
        end
    end

    // read mux; unmapped addresses answer zero
    always_comb begin
        next_rdata = 8'h00;
        case (REG_ADDR)
            `AFMC_OFF_SC1: begin
                next_rdata = {conversion_complete_flag, 1'b0,
                              continuous_conversion, channel_select};
            end
            `AFMC_OFF_MODE: next_rdata = mode_clock_control;
            `AFMC_OFF_FIFO: begin
                next_rdata = {1'b0, fifo_scan_enable,
                              compare_combine_select, 2'h0, fifo_depth};
            end
            // result pair reads the fifo head in fifo mode, else the result register
            `AFMC_OFF_RES_HI: begin
                next_rdata = {6'h00, fifo_en ? res_q.rdata[9:8]
                                             : result[9:8]};
            end
            `AFMC_OFF_RES_LO: begin
                next_rdata = fifo_en ? res_q.rdata[7:0] : result[7:0];
            end
            `AFMC_OFF_IRQ_ST: next_rdata = {5'h00, irq_status};
            `AFMC_OFF_IRQ_MASK: next_rdata = {5'h00, irq_mask};
            default: next_rdata = 8'h00;
        endcase
    end

    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            REG_RDATA <= 8'h00;
        end else begin
            REG_RDATA <= REG_RD ? next_rdata : 8'h00;
        end
    end

endmodule : afmc_ctrl

`default_nettype wire

// ---- afmc_ctrl_monitor.sv ----
/* concurrent checks on the afmc_ctrl ports.
   assumes a bind to afmc_ctrl with matching port names. */
`timescale 1ns/1ps
`default_nettype none
module afmc_ctrl_monitor (
    input wire logic MCLK,
    input wire logic RST_B,
    input wire logic [7:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire logic [7:0] REG_RDATA,
    input wire logic IRQ,
    input wire logic ALT_CLK_TICK,
    input wire logic ASYNC_CLK_TICK,
    input wire logic CONV_CLK_TICK,
    input wire logic CONV_START,
    input wire logic [4:0] CONV_CHANNEL,
    input wire logic CONV_RES_10,
    input wire logic CONV_DONE
);
    logic [7:0] mode;
    logic [7:0] fifo;
    logic src, mw, fw;
    default clocking @(posedge MCLK); endclocking
    default disable iff (!RST_B);
    assign mw = REG_WR && REG_ADDR == 8'h12;
    assign fw = REG_WR && REG_ADDR == 8'h13;
    // register shadows
    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            mode <= 8'h00;
            fifo <= 8'h00;
        end else if (mw) begin
            mode <= REG_WDATA[3] ? {REG_WDATA[7:4], mode[3:2],
                REG_WDATA[1:0]} : REG_WDATA;
        end else if (fw) begin
            fifo <= REG_WDATA & 8'h67;
        end
    end
    assign src = mode[0] ? ASYNC_CLK_TICK : ALT_CLK_TICK;
    property p_fifo_rsvd;
        $past(REG_RD) && $past(REG_ADDR) == 8'h13 |-> (REG_RDATA & 8'h98) == 8'h00;
    endproperty
    a_fifo_rsvd: assert property (p_fifo_rsvd) else $error("fifo reserved bits");
    property p_res_ok;
        mw && !REG_WDATA[3] |=> CONV_RES_10 == $past(REG_WDATA[2]);
    endproperty
    a_res_ok: assert property (p_res_ok) else $error("resolution select");
    property p_res_rsvd;
        mw && REG_WDATA[3] |=> $stable(CONV_RES_10);
    endproperty
    a_res_rsvd: assert property (p_res_rsvd) else $error("reserved resolution");
    property p_clk_sel;
        !mw && mode[1] && mode[6:5] == 2'h0 |=> CONV_CLK_TICK == $past(src);
    endproperty
    a_clk_sel: assert property (p_clk_sel) else $error("alt or async tick");
    property p_clk_bus;
        !mw && mode[1:0] == 2'h0 && mode[6:5] == 2'h0 |=> CONV_CLK_TICK;
    endproperty
    a_clk_bus: assert property (p_clk_bus) else $error("bus clock tick");
    property p_fifo_hold;
        fw && REG_WDATA[2:0] != 3'h0 |-> ##2 !CONV_START [*3];
    endproperty
    a_fifo_hold: assert property (p_fifo_hold) else $error("early start");
    property p_single;
        REG_WR && REG_ADDR == 8'h10 && fifo[2:0] == 3'h0 |-> ##[1:4] CONV_START;
    endproperty
    a_single: assert property (p_single) else $error("no single start");
    property p_chan_hold;
        $changed(CONV_CHANNEL) |-> CONV_START;
    endproperty
    a_chan_hold: assert property (p_chan_hold) else $error("channel moved");
    property p_res_hi;
        $past(REG_RD) && $past(REG_ADDR) == 8'h14 |-> REG_RDATA[7:2] == 6'h00;
    endproperty
    a_res_hi: assert property (p_res_hi) else $error("result high bits");
    c_scan: cover property (CONV_START && fifo[6]);
    c_and: cover property (CONV_DONE && fifo[5]);
    c_irq: cover property ($rose(IRQ));
endmodule : afmc_ctrl_monitor
bind afmc_ctrl afmc_ctrl_monitor u_afmc_ctrl_monitor (.*);
`default_nettype wire

// ---- afmc_conv_model.sv ----
/* converter model: answers each start after LAT cycles.
   assumes LAT is at least one; result is the channel twice. */
`timescale 1ns/1ps
`default_nettype none
module afmc_conv_model (
    input wire logic MCLK,
    input wire logic RST_B,
    input wire logic CONV_START,
    input wire logic [4:0] CONV_CHANNEL,
    input wire logic [3:0] LAT,
    output logic CONV_DONE,
    output logic [9:0] CONV_RESULT,
    output logic CONV_CMP_HIT
);
    logic [3:0] cnt;
    logic [4:0] ch;
    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            cnt <= 4'h0;
            ch <= 5'h00;
            CONV_DONE <= 1'b0;
            CONV_RESULT <= 10'h3ff;
            CONV_CMP_HIT <= 1'b0;
        end else begin
            CONV_DONE <= 1'b0;
            // outside the done cycle the data toggle, never hold
            CONV_RESULT <= ~CONV_RESULT;
            CONV_CMP_HIT <= ~CONV_CMP_HIT;
            if (CONV_START) begin
                cnt <= LAT;
                ch <= CONV_CHANNEL;
            end else if (cnt != 4'h0) begin
                cnt <= cnt - 4'h1;
                if (cnt == 4'h1) begin
                    CONV_DONE <= 1'b1;
                    CONV_RESULT <= {ch, ch};
                    CONV_CMP_HIT <= ch[0];
                end
            end
        end
    end
endmodule : afmc_conv_model
`default_nettype wire

// ---- adc_fifo_mode_control_bench.sv ----
/* self-checking bench for afmc_ctrl with a converter model.
   assumes the design, checker and model are compiled first. */
`timescale 1ns/1ps
`default_nettype none
module adc_fifo_mode_control_bench;
    logic mclk, rst_b, reg_wr, reg_rd, alt, asy, done, hit, tick;
    logic start, res10, irq, an, orr;
    logic [7:0] addr, wdata, rdata, v;
    logic [3:0] lat;
    logic [4:0] chan, c;
    logic [9:0] result;
    logic [4:0] q[$];
    logic [4:0] sq[$];
    logic [7:0] ra[5] = '{8'h10, 8'h12, 8'h13, 8'h19, 8'h3f};
    logic [7:0] re[5] = '{8'h1f, 8'h00, 8'h00, 8'h00, 8'h00};
    logic [7:0] mw[4] = '{8'h04, 8'h08, 8'h00, 8'h0c};
    logic [7:0] mr[4] = '{8'h04, 8'h04, 8'h00, 8'h00};
    logic [7:0] ck[7] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h20, 8'h40, 8'h60};
    integer miscompares = 0, checks = 0, seed = 32'h641b, dones = 0;
    integer i, t, d, s, e, n, na, nb, w;
    afmc_ctrl u_afmc_ctrl (.MCLK(mclk), .RST_B(rst_b), .REG_ADDR(addr),
        .REG_WDATA(wdata), .REG_WR(reg_wr), .REG_RD(reg_rd),
        .REG_RDATA(rdata), .IRQ(irq), .ALT_CLK_TICK(alt),
        .ASYNC_CLK_TICK(asy), .CONV_CLK_TICK(tick), .CONV_START(start),
        .CONV_CHANNEL(chan), .CONV_RES_10(res10), .CONV_LOW_POWER(),
        .CONV_LONG_SAMPLE(), .CONV_DONE(done), .CONV_RESULT(result),
        .CONV_CMP_HIT(hit));
    afmc_conv_model u_afmc_conv_model (.MCLK(mclk), .RST_B(rst_b),
        .CONV_START(start), .CONV_CHANNEL(chan), .LAT(lat),
        .CONV_DONE(done), .CONV_RESULT(result), .CONV_CMP_HIT(hit));
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        alt <= 1'($random(seed));
        asy <= 1'($random(seed));
        dones <= dones + done;
        if (start) sq.push_back(chan);
    end
    function automatic integer ticks_of(input logic [7:0] m, input integer a,
        input integer b);
        case (m[1:0])
            2'h0: return 40 >> m[6:5];
            2'h1: return 20;
            2'h2: return a;
            default: return b;
        endcase
    endfunction : ticks_of
    task automatic test_done;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : test_done
    task automatic chk(input logic [9:0] got, input logic [9:0] exp);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] dat);
        @(posedge mclk);
        addr <= a;
        wdata <= dat;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
        #1;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] dat);
        @(posedge mclk);
        addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 dat = rdata;
    endtask : rd
    task automatic wait_done(input integer want);
        for (w = 0; w < 400 && dones < want; w++) @(posedge mclk);
        if (dones < want) begin
            miscompares++;
            test_done();
        end
    endtask : wait_done
    initial begin
        rst_b = 1'b0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        addr = 8'h00;
        wdata = 8'h00;
        alt = 1'b0;
        asy = 1'b0;
        lat = 4'h3;
        repeat (16) @(posedge mclk);
        rst_b <= 1'b1;
        for (i = 0; i < 5; i++) begin
            rd(ra[i], v);
            chk(v, re[i]);
        end
        for (i = 0; i < 4; i++) begin
            t = i == 0 ? 32'hff : $random(seed);
            wr(8'h13, t[7:0]);
            rd(8'h13, v);
            chk(v, t[7:0] & 8'h67);
        end
        wr(8'h13, 8'h00);
        for (i = 0; i < 4; i++) begin
            wr(8'h12, mw[i]);
            chk(res10, mr[i][2]);
            rd(8'h12, v);
            chk(v, mr[i]);
        end
        for (i = 0; i < 7; i++) begin
            wr(8'h12, ck[i]);
            n = 0;
            na = 0;
            nb = 0;
            repeat (40) begin
                na += alt;
                nb += asy;
                @(posedge mclk);
                #1 n += tick;
            end
            chk(10'(n), 10'(ticks_of(ck[i], na, nb)));
        end
        // bus clock twice the converter clock before fifo use
        wr(8'h12, 8'h24);
        for (i = 0; i < 2; i++) begin
            wr(8'h19, 8'(!i));
            e = dones;
            wr(8'h10, 8'h05);
            wait_done(e + 1);
            repeat (3) @(posedge mclk);
            #1 chk(sq[sq.size() - 1], 5'h05);
            chk(irq, !i);
            rd(8'h15, v);
            chk(v, 8'ha5);
            rd(8'h18, v);
            chk(v, 8'h01);
            @(posedge mclk);
            #1 chk(irq, 1'b0);
        end
        for (t = 0; t < 8; t++) begin
            d = t == 0 ? 1 : t == 1 ? 7 : 1 + {$random(seed)} % 7;
            lat <= 4'(1 + {$random(seed)} % 9);
            wr(8'h13, {1'b0, t[2], t[0], 2'b00, 3'(d)});
            s = sq.size();
            e = dones;
            q.delete();
            an = 1'b1;
            orr = 1'b0;
            for (i = 0; i <= d; i++) begin
                chk(10'(sq.size() - s), 10'h000);
                q.push_back(5'($random(seed)));
                c = t[2] ? q[0] : q[i];
                an &= c[0];
                orr |= c[0];
                wr(8'h10, {2'b00, t == 7, q[i]});
            end
            wait_done(e + d + 1);
            repeat (4) @(posedge mclk);
            rd(8'h10, v);
            chk(v[7], t[0] ? an : orr);
            if (t == 7) chk(sq[s + d + 1], q[0]);
            for (i = 0; i <= d; i++) begin
                c = t[2] ? q[0] : q[i];
                chk(sq[s + i], c);
                rd(8'h14, v);
                chk(v, {8'h00, c[4:3]});
                rd(8'h15, v);
                chk(v, {c[2:0], c});
            end
            wr(8'h13, 8'h00);
            repeat (12) @(posedge mclk);
        end
        test_done();
    end
endmodule : adc_fifo_mode_control_bench
`default_nettype wire
